// *** adcr_pkg.sv ***
/*
 * Shared constants for the parallel result read-out block: register map,
 * field positions, reset values, timing counts and the read-out states.
 * Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
`default_nettype none

package adcr_pkg;

	// Clock and timing.
	localparam int CLK_PERIOD_NS     = 10;
	localparam int CONV_TIME_NS      = 4700;
	localparam int CONV_CYCLES       = CONV_TIME_NS / CLK_PERIOD_NS;
	localparam int DATA_OUT_DELAY_NS = 20;
	localparam int DATA_OUT_CYCLES   = (DATA_OUT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CONV_CNT_W        = 9;
	localparam int DLY_CNT_W         = 2;

	// Result geometry.
	localparam int RESULT_W = 14;
	localparam int BYTE_W   = 8;
	localparam int HIGH_W   = RESULT_W - BYTE_W;

	// Register map, byte addresses.
	localparam logic [3:0] ADDR_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_RESULT = 4'h8;
	localparam logic [3:0] ADDR_COUNT  = 4'hC;

	// Control register fields.
	localparam int CTRL_BIPOLAR_BIT       = 0;
	localparam logic CTRL_BIPOLAR_RESET   = 1'b1;

	// Status register fields.
	localparam int STAT_STATE_LSB    = 0;
	localparam int STAT_EOC_BIT      = 4;
	localparam int STAT_SHUTDOWN_BIT = 5;
	localparam int STAT_POWERED_BIT  = 6;
	localparam int STAT_REF_BIT      = 7;
	localparam int STAT_BUS_BIT      = 8;

	// AXI responses.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		ST_OFF,
		ST_ACQUIRE,
		ST_CONVERT,
		ST_DONE,
		ST_READ
	} adcr_state_t;

endpackage

`default_nettype wire

// *** adcr_axi_regs.sv ***
/*
 * AXI4-Lite register slave for the result read-out block: one control
 * register and three read-only words of block state.
 * Assumes at most one write and one read outstanding, as AXI4-Lite masters do.
 */
`timescale 1ns/1ps
`default_nettype none

module adcr_axi_regs (
	// Clock and reset.
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Write address and data.
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// Write response.
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// Read address and data.
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Block side.
	output logic             bipolar_mode,
	input  wire logic [31:0] status_word,
	input  wire logic [31:0] result_word,
	input  wire logic [31:0] count_word
);

	logic [3:0]  aw_addr_q;
	logic        aw_have_q;
	logic [31:0] w_data_q;
	logic        w_strb0_q;
	logic        w_have_q;
	logic        bipolar_q;
	wire         aw_take  = s_axi_awvalid && s_axi_awready;
	wire         w_take   = s_axi_wvalid && s_axi_wready;
	wire         do_write = aw_have_q && w_have_q && !s_axi_bvalid;
	wire         wr_ctrl  = aw_addr_q == adcr_pkg::ADDR_CTRL;
	wire         wr_ok    = wr_ctrl || aw_addr_q == adcr_pkg::ADDR_STATUS
	                        || aw_addr_q == adcr_pkg::ADDR_RESULT || aw_addr_q == adcr_pkg::ADDR_COUNT;
	wire         ar_take  = s_axi_arvalid && s_axi_arready;
	wire         rd_hit   = s_axi_araddr == adcr_pkg::ADDR_CTRL || s_axi_araddr == adcr_pkg::ADDR_STATUS
	                        || s_axi_araddr == adcr_pkg::ADDR_RESULT || s_axi_araddr == adcr_pkg::ADDR_COUNT;
	wire [31:0]  rd_mux   = (s_axi_araddr == adcr_pkg::ADDR_CTRL)   ? {31'h0, bipolar_q} :
	                        (s_axi_araddr == adcr_pkg::ADDR_STATUS) ? status_word :
	                        (s_axi_araddr == adcr_pkg::ADDR_RESULT) ? result_word :
	                        (s_axi_araddr == adcr_pkg::ADDR_COUNT)  ? count_word : 32'h0;

	assign bipolar_mode  = bipolar_q;

	// The ready flags are kept as flops of their own so that the bus sees no logic behind them.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q     <= 1'b0;
			aw_addr_q     <= 4'h0;
			s_axi_awready <= 1'b1;
		end else if (aw_take) begin
			aw_have_q     <= 1'b1;
			aw_addr_q     <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end else if (do_write) begin
			aw_have_q     <= 1'b0;
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_have_q     <= 1'b0;
			w_data_q     <= 32'h0;
			w_strb0_q    <= 1'b0;
			s_axi_wready <= 1'b1;
		end else if (w_take) begin
			w_have_q     <= 1'b1;
			w_data_q     <= s_axi_wdata;
			w_strb0_q    <= s_axi_wstrb[0];
			s_axi_wready <= 1'b0;
		end else if (do_write) begin
			w_have_q     <= 1'b0;
			s_axi_wready <= 1'b1;
		end
	end

	// Only the control word is writable; the other words ignore writes.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bipolar_q <= adcr_pkg::CTRL_BIPOLAR_RESET;
		end else if (do_write && wr_ctrl && w_strb0_q) begin
			bipolar_q <= w_data_q[adcr_pkg::CTRL_BIPOLAR_BIT];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= adcr_pkg::RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_ok ? adcr_pkg::RESP_OKAY : adcr_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= adcr_pkg::RESP_OKAY;
			s_axi_arready <= 1'b1;
		end else if (ar_take) begin
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_mux;
			s_axi_rresp   <= rd_hit ? adcr_pkg::RESP_OKAY : adcr_pkg::RESP_SLVERR;
			s_axi_arready <= 1'b0;
		end else if (s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule

`default_nettype wire

// *** adcr_readout.sv ***
/*
 * Parallel result read-out logic of a 14-bit successive-approximation
 * converter: select-edge sequencing, conversion timing, end-of-conversion
 * flag, power-mode selection and the byte-wide three-state result bus.
 * Assumes the host pins are already synchronous to aclk and that the
 * converter core presents its finished code on sample_code when asked.
 */
`timescale 1ns/1ps
`default_nettype none

module adcr_readout (
	// Clock and reset.
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	// Host parallel pins.
	input  wire logic                          select_n,
	input  wire logic                          read_convert,
	input  wire logic                          upper_byte_select,
	output logic                               eoc_n,
	output logic [adcr_pkg::BYTE_W-1:0]        result_bus_o,
	output logic                               result_bus_oe,
	// Converter core.
	input  wire logic [adcr_pkg::RESULT_W-1:0] sample_code,
	output logic                               sample_hold,
	output logic                               analog_powered,
	output logic                               reference_on,
	// AXI4-Lite register bus.
	input  wire logic [3:0]                    s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [3:0]                    s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic [31:0]                        s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready
);

	// Picks one byte of the coded result; the high byte is zero-extended.
	function automatic logic [adcr_pkg::BYTE_W-1:0] pick_byte(
		input logic [adcr_pkg::RESULT_W-1:0] code,
		input logic                          upper
	);
		logic [adcr_pkg::BYTE_W-1:0] hi;
		hi = {{(adcr_pkg::BYTE_W - adcr_pkg::HIGH_W){1'b0}}, code[adcr_pkg::RESULT_W-1:adcr_pkg::BYTE_W]};
		pick_byte = upper ? hi : code[adcr_pkg::BYTE_W-1:0];
	endfunction

	adcr_pkg::adcr_state_t state_q;
	adcr_pkg::adcr_state_t state_d;
	logic                              select_n_q;
	logic [adcr_pkg::CONV_CNT_W-1:0]   conv_cnt_q;
	logic [adcr_pkg::DLY_CNT_W-1:0]    dly_cnt_q;
	logic                              shutdown_q;
	logic                              ref_q;
	logic [adcr_pkg::RESULT_W-1:0]     result_q;
	logic [31:0]                       count_q;
	logic                              bipolar_mode;

	// Select edges and the sequencing events derived from them.
	wire select_fall = select_n_q && !select_n;
	wire select_rise = !select_n_q && select_n;
	wire start_acq   = select_fall && !read_convert;
	wire start_conv  = state_q == adcr_pkg::ST_ACQUIRE && select_fall;
	wire conv_end    = state_q == adcr_pkg::ST_CONVERT
	                   && conv_cnt_q == adcr_pkg::CONV_CNT_W'(adcr_pkg::CONV_CYCLES - 1);
	wire start_read  = state_q == adcr_pkg::ST_DONE && select_fall && read_convert;
	wire drive_ready = state_q == adcr_pkg::ST_READ
	                   && dly_cnt_q == adcr_pkg::DLY_CNT_W'(adcr_pkg::DATA_OUT_CYCLES);

	// A bipolar code arrives two's complement; flipping the sign bit gives offset binary.
	wire [adcr_pkg::RESULT_W-1:0] coded = bipolar_mode
	                                      ? {~sample_code[adcr_pkg::RESULT_W-1],
	                                         sample_code[adcr_pkg::RESULT_W-2:0]}
	                                      : sample_code;

	wire [adcr_pkg::BYTE_W-1:0] bus_byte = pick_byte(result_q, upper_byte_select);

	wire [31:0] status_word = {23'h0,
	                           result_bus_oe,
	                           ref_q,
	                           analog_powered,
	                           shutdown_q,
	                           eoc_n,
	                           1'b0,
	                           state_q};
	wire [31:0] result_word = {{(32 - adcr_pkg::RESULT_W){1'b0}}, result_q};

	assign reference_on = ref_q;

	// Sequencing of acquire, convert, hold result and read.
	always_comb begin
		state_d = state_q;
		case (state_q)
			adcr_pkg::ST_OFF: begin
				if (start_acq) begin
					state_d = adcr_pkg::ST_ACQUIRE;
				end
			end
			adcr_pkg::ST_ACQUIRE: begin
				if (select_fall) begin
					state_d = adcr_pkg::ST_CONVERT;
				end
			end
			adcr_pkg::ST_CONVERT: begin
				if (conv_end) begin
					state_d = adcr_pkg::ST_DONE;
				end
			end
			adcr_pkg::ST_DONE: begin
				if (start_read) begin
					state_d = adcr_pkg::ST_READ;
				end else if (start_acq) begin
					state_d = adcr_pkg::ST_ACQUIRE;
				end
			end
			adcr_pkg::ST_READ: begin
				if (select_rise) begin
					state_d = adcr_pkg::ST_OFF;
				end
			end
			default: begin
				state_d = adcr_pkg::ST_OFF;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q    <= adcr_pkg::ST_OFF;
			select_n_q <= 1'b1;
		end else begin
			state_q    <= state_d;
			select_n_q <= select_n;
		end
	end

	// Conversion time counter; the flag falls within the longest conversion time.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			conv_cnt_q <= '0;
		end else if (state_q == adcr_pkg::ST_CONVERT) begin
			conv_cnt_q <= conv_cnt_q + 1'b1;
		end else begin
			conv_cnt_q <= '0;
		end
	end

	// Result latch and conversion counter.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			result_q <= '0;
			count_q  <= 32'h0;
		end else if (conv_end) begin
			result_q <= coded;
			count_q  <= count_q + 32'h1;
		end
	end

	// The flag rises again when the next acquisition begins.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			eoc_n <= 1'b1;
		end else if (conv_end) begin
			eoc_n <= 1'b0;
		end else if (state_q != adcr_pkg::ST_READ && start_acq) begin
			eoc_n <= 1'b1;
		end
	end

	// Power mode chosen at the fall that ends acquisition.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shutdown_q <= 1'b1;
		end else if (start_conv) begin
			shutdown_q <= read_convert;
		end
	end

	// Reference stays on in standby and drops after conversion in shutdown.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ref_q <= 1'b0;
		end else if (state_q != adcr_pkg::ST_READ && start_acq) begin
			ref_q <= 1'b1;
		end else if (conv_end && shutdown_q) begin
			ref_q <= 1'b0;
		end
	end

	// Core power follows the sequence: fully off between conversions in shutdown.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			analog_powered <= 1'b0;
			sample_hold    <= 1'b0;
		end else begin
			analog_powered <= state_d == adcr_pkg::ST_ACQUIRE || state_d == adcr_pkg::ST_CONVERT
			                  || (!shutdown_q && state_d != adcr_pkg::ST_OFF) || (!shutdown_q && ref_q);
			sample_hold    <= state_d == adcr_pkg::ST_CONVERT;
		end
	end

	// Output delay counter between the read fall and driving the bus.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dly_cnt_q <= '0;
		end else if (state_q == adcr_pkg::ST_READ && !drive_ready) begin
			dly_cnt_q <= dly_cnt_q + 1'b1;
		end else if (state_q != adcr_pkg::ST_READ) begin
			dly_cnt_q <= '0;
		end
	end

	// The bus is driven only in the read phase; every other state keeps it released.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			result_bus_oe <= 1'b0;
			result_bus_o  <= '0;
		end else if (select_rise || state_q != adcr_pkg::ST_READ) begin
			result_bus_oe <= 1'b0;
			result_bus_o  <= '0;
		end else if (drive_ready) begin
			result_bus_oe <= 1'b1;
			result_bus_o  <= bus_byte;
		end
	end

	adcr_axi_regs u_regs (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.bipolar_mode  (bipolar_mode),
		.status_word   (status_word),
		.result_word   (result_word),
		.count_word    (count_q)
	);

endmodule

`default_nettype wire

// *** adcr_readout_sva.sv ***
/* Assertions on the host pins of adcr_readout.
   Sees only the top module's ports; bound below. */
`timescale 1ns/1ps
`default_nettype none
module adcr_readout_sva (
	// Clock and reset.
	input wire logic                        aclk,
	input wire logic                        aresetn,
	// Host pins.
	input wire logic                        select_n,
	input wire logic                        read_convert,
	input wire logic                        upper_byte_select,
	input wire logic                        eoc_n,
	input wire logic [adcr_pkg::BYTE_W-1:0] result_bus_o,
	input wire logic                        result_bus_oe,
	// Core side.
	input wire logic                        sample_hold,
	input wire logic                        analog_powered
);
	logic      sel_q;
	logic      sd_q;
	wire logic sd_d;
	wire logic convert_fall;
	// The power choice is only visible at the convert fall, so it is mirrored here.
	assign convert_fall = sel_q & ~select_n & analog_powered & eoc_n & ~sample_hold;
	assign sd_d         = convert_fall ? read_convert : sd_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sel_q <= 1'b1;
			sd_q  <= 1'b1;
		end else begin
			sel_q <= select_n;
			sd_q  <= sd_d;
		end
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_conv_time; $rose(sample_hold) |-> ##[1:471] !eoc_n; endproperty
	a_conv_time: assert property (p_conv_time) else $error("flag late after hold");
	property p_hiz; (sample_hold || eoc_n) |-> !result_bus_oe; endproperty
	a_hiz: assert property (p_hiz) else $error("bus driven before result valid");
	property p_oe_early; $fell(select_n) && read_convert && !eoc_n |=> !result_bus_oe [*2]; endproperty
	a_oe_early: assert property (p_oe_early) else $error("bus driven too soon");
	property p_oe_late; $fell(select_n) && read_convert && !eoc_n ##1 !select_n [*5] |-> result_bus_oe; endproperty
	a_oe_late: assert property (p_oe_late) else $error("bus not driven on read");
	property p_release; select_n ##1 select_n |-> !result_bus_oe; endproperty
	a_release: assert property (p_release) else $error("bus held after deselect");
	property p_top_zero; result_bus_oe && upper_byte_select |-> result_bus_o[7:6] == 2'b00; endproperty
	a_top_zero: assert property (p_top_zero) else $error("high byte top bits set");
	property p_wake; $fell(select_n) && !read_convert && !sample_hold |-> ##[1:2] (analog_powered && eoc_n); endproperty
	a_wake: assert property (p_wake) else $error("no acquisition on start");
	property p_ignore; $fell(select_n) && read_convert && !analog_powered && eoc_n |-> ##2 !analog_powered; endproperty
	a_ignore: assert property (p_ignore) else $error("start with read high not ignored");
	property p_power; $fell(eoc_n) |-> ##2 (analog_powered == !sd_q); endproperty
	a_power: assert property (p_power) else $error("wrong power state after conversion");
endmodule
bind adcr_readout adcr_readout_sva u_sva (.aclk(aclk), .aresetn(aresetn), .select_n(select_n),
	.read_convert(read_convert), .upper_byte_select(upper_byte_select), .eoc_n(eoc_n),
	.result_bus_o(result_bus_o), .result_bus_oe(result_bus_oe), .sample_hold(sample_hold),
	.analog_powered(analog_powered));
`default_nettype wire

// *** adcr_host_model.sv ***
/* Host processor on the parallel pins: starts, converts and reads.
   Assumes its tasks are entered just after a rising aclk edge. */
`timescale 1ns/1ps
`default_nettype none
module adcr_host_model #(
	// Reference settling wait, shortened from milliseconds to keep runs brief.
	parameter int WAKE_CYCLES = 40
) (
	// Clock.
	input wire logic       aclk,
	// Device pins.
	input wire logic       eoc_n,
	input wire logic [7:0] result_bus_o,
	input wire logic       result_bus_oe,
	output var logic       select_n,
	output var logic       read_convert,
	output var logic       upper_byte_select
);
	initial begin
		select_n = 1'b1;
		read_convert = 1'b1;
		upper_byte_select = 1'b0;
	end
	task automatic pulse(input logic rc);
		select_n <= 1'b0;
		read_convert <= rc;
		@(posedge aclk);
		select_n <= 1'b1;
		@(posedge aclk);
	endtask
	task automatic sample(input logic shutdown, input int acq, output logic ok);
		int n;
		repeat (WAKE_CYCLES) @(posedge aclk);
		pulse(1'b0);
		repeat (acq) @(posedge aclk);
		pulse(shutdown);
		n = 0;
		while (eoc_n !== 1'b0 && n < 600) begin
			@(posedge aclk);
			n++;
		end
		ok = (n < 600);
	endtask
	task automatic read_byte(input logic upper, output logic [7:0] b, output logic ok);
		select_n <= 1'b0;
		read_convert <= 1'b1;
		upper_byte_select <= upper;
		repeat (6) @(posedge aclk);
		b = result_bus_o;
		ok = (result_bus_oe === 1'b1);
		select_n <= 1'b1;
		repeat (2) @(posedge aclk);
	endtask
endmodule
`default_nettype wire

// *** tb.sv ***
/* Self-checking bench for adcr_readout with a host model and AXI4-Lite tasks.
   Assumes the package constants of adcr_pkg. */
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        aclk, aresetn, eoc_n, result_bus_oe, sample_hold, analog_powered, reference_on;
	logic        select_n, read_convert, upper_byte_select;
	logic [7:0]  result_bus_o;
	logic [13:0] sample_code;
	logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int          mismatches, tests_run;
	adcr_readout i_adcr_readout (.aclk, .aresetn, .select_n, .read_convert, .upper_byte_select, .eoc_n,
		.result_bus_o, .result_bus_oe, .sample_code, .sample_hold, .analog_powered, .reference_on,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	adcr_host_model u_host (.aclk, .eoc_n, .result_bus_o, .result_bus_oe, .select_n, .read_convert,
		.upper_byte_select);
	always #5 aclk = ~aclk;
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic guard(input logic ok);
		if (!ok) begin
			mismatches++;
			$display("[ERR] %0t wait limit reached", $time);
			test_done();
		end
	endtask
	task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 50);
		guard(n < 50);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 50);
		guard(n < 50);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
	// Bipolar codes come out in offset binary: the sign bit is inverted.
	function automatic logic [13:0] coded(input logic [13:0] c, input logic bip);
		return bip ? {~c[13], c[12:0]} : c;
	endfunction
	initial begin
		logic [31:0] d, cnt0;
		logic [1:0]  r;
		logic [7:0]  b;
		logic [13:0] e;
		logic        ok, bip;
		logic [13:0] corner [4];
		corner = '{14'h0000, 14'h3FFF, 14'h2000, 14'h1FFF};
		void'($urandom(48688));
		{aclk, aresetn, mismatches, tests_run} = '0;
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		sample_code = 14'h0000;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk(eoc_n, 1'b1);
		chk(result_bus_oe, 1'b0);
		axr(adcr_pkg::ADDR_CTRL, d, r);
		chk(d, 32'h1);
		axr(4'h2, d, r);
		chk(r, adcr_pkg::RESP_SLVERR);
		axr(adcr_pkg::ADDR_COUNT, cnt0, r);
		chk(cnt0, 32'h0);
		chk(reference_on, 1'b0);
		u_host.pulse(1'b1);
		repeat (3) @(posedge aclk);
		chk(analog_powered, 1'b0);
		chk(eoc_n, 1'b1);
		for (int i = 0; i < 8; i++) begin
			bip = (i < 4);
			if (i == 4) begin
				axw(adcr_pkg::ADDR_CTRL, 32'h0, r);
				chk(r, adcr_pkg::RESP_OKAY);
			end
			sample_code <= (i < 4) ? corner[i] : 14'($urandom);
			u_host.sample(i[0], 1 + int'($urandom % 20), ok);
			guard(ok);
			chk(result_bus_oe, 1'b0);
			chk(analog_powered, !i[0]);
			chk(reference_on, !i[0]);
			u_host.read_byte(i[1], b, ok);
			guard(ok);
			e = coded(sample_code, bip);
			chk(b, i[1] ? {2'b00, e[13:8]} : e[7:0]);
			chk(result_bus_oe, 1'b0);
			axr(adcr_pkg::ADDR_RESULT, d, r);
			chk(d, {18'h0, e});
		end
		axr(adcr_pkg::ADDR_COUNT, d, r);
		chk(d, cnt0 + 32'h8);
		test_done();
	end
endmodule
`default_nettype wire
